// File: hw/rcb_consts.vh
// constants for the rt circular buffer manager
`ifndef RCB_CONSTS_VH
`define RCB_CONSTS_VH
// axi4-lite register byte offsets
`define RCB_OFS_CFG2 8'h00
`define RCB_OFS_CFG3 8'h04
`define RCB_OFS_ISTAT 8'h08
`define RCB_OFS_IMASK 8'h0C
`define RCB_OFS_STATE 8'h10
`define RCB_OFS_PTR 8'h14
// configuration register 2 field positions
`define RCB_CFG2_BCAST_SEP 0
`define RCB_CFG2_PER_SA 1
`define RCB_CFG2_ADV_VALID 11
`define RCB_CFG2_PINGPONG 12
// configuration register 3 field positions
`define RCB_CFG3_EXT_EN 15
// subaddress control word fields
`define RCB_SACW_WRAP_IRQ 8
`define RCB_SACW_DBUF 15
// reset values
`define RCB_CFG2_RST 16'h0000
`define RCB_CFG3_RST 16'h0000
// interrupt status bits
`define RCB_IRQ_ROLL 0
`define RCB_IRQ_EOM 1
// memory management codes
`define RCB_MM_SINGLE 3'h0
// buffer handling modes
`define RCB_MODE_SINGLE 2'h0
`define RCB_MODE_DOUBLE 2'h1
`define RCB_MODE_CIRC 2'h2
`endif

// File: hw/rcb_addr_step.v
// modulo address stepper for the circular data pointer
`include "rcb_consts.vh"
module rcb_addr_step #(
  parameter AW = 16
) (
  input wire [AW-1:0] addr_i,
  input wire [2:0] mm_i,
  input wire circ_i,
  output wire [AW-1:0] next_o,
  output wire wrap_o
);
  // mask of low bits that roll; code 1 is 128 words up to code 7 for 8192
  function [AW-1:0] size_mask;
    input [2:0] mm;
    begin
      // shift kept four bits wide: mm plus six overflows three bits
      size_mask = ({{(AW-1){1'b0}}, 1'b1} << ({1'b0, mm} + 4'h6)) - 1'b1;
    end
  endfunction
  wire [AW-1:0] mask;
  wire [AW-1:0] inc;
  assign mask = size_mask(mm_i);
  assign inc = addr_i + 1'b1;
  // high bits are frozen so no access leaves the buffer
  assign next_o = circ_i ? ((addr_i & ~mask) | (inc & mask)) : inc;
  assign wrap_o = circ_i & ((addr_i & mask) == mask);
endmodule

// File: hw/rcb_top.v
// rt data buffer manager: lookup pointer handling and axi4-lite registers
`include "rcb_consts.vh"
// Overview of operation
// - per-subaddress single or circular selection
// - copy lookup pointer to descriptor word three
// - circular data accesses consecutive from pointer
// - advance bit clear: always write back pointer
// - advance bit set: write back only if valid
// - wrap pointer from upper to lower buffer boundary
// - sizes 128 to 8192 words, modulo wrap
// - rollover interrupt when wrap enable set
// - all enables zero: single message everywhere
// - ping-pong plus extended: double buffer receives
// - per-subaddress bit enables selected double buffers
// - config2 bit1 per-subaddress management enable
// - config2 bit0 separates broadcast lookup entries
module rcb_top #(
  parameter AW = 16,
  parameter LUT_BASE = 16'h0140,
  parameter BCAST_BASE = 16'h0180,
  parameter SACW_BASE = 16'h01A0
) (
  input wire clock_i,
  input wire rst_n_i,
  // axi4-lite slave
  input wire [7:0] s_awaddr_i,
  input wire s_awvalid_i,
  output wire s_awready_o,
  input wire [31:0] s_wdata_i,
  input wire [3:0] s_wstrb_i,
  input wire s_wvalid_i,
  output wire s_wready_o,
  output reg [1:0] s_bresp_o,
  output reg s_bvalid_o,
  input wire s_bready_i,
  input wire [7:0] s_araddr_i,
  input wire s_arvalid_i,
  output wire s_arready_o,
  output reg [31:0] s_rdata_o,
  output reg [1:0] s_rresp_o,
  output reg s_rvalid_o,
  input wire s_rready_i,
  // message sequencer side (same clock)
  input wire msg_start_i,
  input wire [4:0] msg_sa_i,
  input wire msg_tx_i,
  input wire msg_bcast_i,
  input wire [AW-1:0] desc_addr_i,
  input wire word_step_i,
  input wire msg_end_i,
  input wire msg_valid_i,
  output wire busy_o,
  output reg [AW-1:0] data_addr_o,
  output reg [1:0] buf_mode_o,
  // shared ram master port
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [AW-1:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  input wire mem_ack_i,
  input wire [15:0] mem_rdata_i,
  output wire irq_o
);
  // ==========================================================
  // sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_RD_CW = 3'h1;
  localparam S_RD_LUT = 3'h2;
  localparam S_WR_DESC = 3'h3;
  localparam S_XFER = 3'h4;
  localparam S_WR_LUT = 3'h5;

  reg [15:0] cfg2_reg;
  reg [15:0] cfg3_reg;
  reg [1:0] istat_reg;
  reg [1:0] imask_reg;
  reg [2:0] state_reg;
  reg [15:0] cw_reg;
  reg [AW-1:0] lut_addr_reg;
  reg [AW-1:0] desc_reg;
  reg [2:0] mm_reg;
  reg circ_reg;
  reg wrapped_reg;
  reg tx_reg;
  reg bcast_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  wire per_sa = cfg2_reg[`RCB_CFG2_PER_SA];
  wire bsep = cfg2_reg[`RCB_CFG2_BCAST_SEP];
  wire adv_valid = cfg2_reg[`RCB_CFG2_ADV_VALID];
  wire pingpong = cfg2_reg[`RCB_CFG2_PINGPONG];
  wire ext_en = cfg3_reg[`RCB_CFG3_EXT_EN];
  // broadcast gets its own table area only when separated
  wire use_bcast = msg_bcast_i & bsep;
  // per-direction memory management field of the control word
  // direction is latched at start: the sequencer inputs may move on
  wire [2:0] cw_mm = tx_reg ? mem_rdata_i[12:10] :
    (bcast_reg ? mem_rdata_i[2:0] : mem_rdata_i[7:5]);
  wire [AW-1:0] step_next;
  wire step_wrap;

  rcb_addr_step #(
    .AW(AW)
  ) u_step (
    .addr_i(data_addr_o),
    .mm_i(mm_reg),
    .circ_i(circ_reg),
    .next_o(step_next),
    .wrap_o(step_wrap)
  );

  // ==========================================================
  // message sequencer
  assign busy_o = (state_reg != S_IDLE);
  // write back decision: single never, advance bit gates on validity
  wire do_wb = circ_reg & (~adv_valid | msg_valid_i);
  wire roll_ev = (state_reg == S_XFER) & msg_end_i & wrapped_reg & do_wb &
    cw_reg[`RCB_SACW_WRAP_IRQ];
  wire eom_ev = (state_reg == S_XFER) & msg_end_i;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= {AW{1'b0}};
      mem_wdata_o <= 16'h0000;
      data_addr_o <= {AW{1'b0}};
      buf_mode_o <= `RCB_MODE_SINGLE;
      cw_reg <= 16'h0000;
      lut_addr_reg <= {AW{1'b0}};
      desc_reg <= {AW{1'b0}};
      mm_reg <= 3'h0;
      circ_reg <= 1'b0;
      wrapped_reg <= 1'b0;
      tx_reg <= 1'b0;
      bcast_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (msg_start_i) begin
            // control word read each message
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= SACW_BASE + {{(AW-5){1'b0}}, msg_sa_i};
            lut_addr_reg <= (use_bcast ? BCAST_BASE : LUT_BASE) +
              {{(AW-6){1'b0}}, msg_tx_i, msg_sa_i};
            desc_reg <= desc_addr_i + 2'h2;
            wrapped_reg <= 1'b0;
            tx_reg <= msg_tx_i;
            bcast_reg <= use_bcast;
            state_reg <= S_RD_CW;
          end
        end
        S_RD_CW: begin
          if (mem_ack_i) begin
            cw_reg <= mem_rdata_i;
            mm_reg <= cw_mm;
            // circular only under per-subaddress management
            circ_reg <= per_sa & (cw_mm != `RCB_MM_SINGLE);
            if (per_sa && cw_mm != `RCB_MM_SINGLE) begin
              buf_mode_o <= `RCB_MODE_CIRC;
            end else if (!tx_reg && pingpong && ext_en &&
                (!per_sa || mem_rdata_i[`RCB_SACW_DBUF])) begin
              buf_mode_o <= `RCB_MODE_DOUBLE;
            end else begin
              buf_mode_o <= `RCB_MODE_SINGLE;
            end
            mem_addr_o <= lut_addr_reg;
            state_reg <= S_RD_LUT;
          end
        end
        S_RD_LUT: begin
          if (mem_ack_i) begin
            // data pointer starts at lookup entry
            data_addr_o <= mem_rdata_i[AW-1:0];
            mem_we_o <= 1'b1;
            mem_addr_o <= desc_reg;
            mem_wdata_o <= mem_rdata_i;
            state_reg <= S_WR_DESC;
          end
        end
        S_WR_DESC: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            state_reg <= S_XFER;
          end
        end
        S_XFER: begin
          if (word_step_i) begin
            data_addr_o <= step_next;
            if (step_wrap) begin
              wrapped_reg <= 1'b1;
            end
          end
          if (msg_end_i) begin
            if (do_wb) begin
              mem_req_o <= 1'b1;
              mem_we_o <= 1'b1;
              mem_addr_o <= lut_addr_reg;
              mem_wdata_o <= data_addr_o; // address after last word
              state_reg <= S_WR_LUT;
            end else begin
              state_reg <= S_IDLE; // no write back: not circular, or advance bit set and message invalid
            end
          end
        end
        S_WR_LUT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // axi4-lite slave: address and data taken in either order
  wire wr_go = aw_got_reg & w_got_reg & ~s_bvalid_o;
  assign s_awready_o = ~aw_got_reg & ~s_bvalid_o;
  assign s_wready_o = ~w_got_reg & ~s_bvalid_o;
  assign s_arready_o = ~s_rvalid_o;
  wire [15:0] wd = wdata_reg[15:0];
  wire [1:0] w1c = (wr_go && awaddr_reg == `RCB_OFS_ISTAT &&
    wstrb_reg[0]) ? wd[1:0] : 2'h0;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? nw[15:8] : old[15:8],
        strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= 2'h0;
      cfg2_reg <= `RCB_CFG2_RST;
      cfg3_reg <= `RCB_CFG3_RST;
      imask_reg <= 2'h0;
      istat_reg <= 2'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_wdata_i;
        wstrb_reg <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= 2'h0;
        case (awaddr_reg)
          `RCB_OFS_CFG2: cfg2_reg <= merge16(cfg2_reg, wd, wstrb_reg);
          `RCB_OFS_CFG3: cfg3_reg <= merge16(cfg3_reg, wd, wstrb_reg);
          `RCB_OFS_IMASK: begin
            if (wstrb_reg[0]) begin
              imask_reg <= wd[1:0];
            end
          end
          `RCB_OFS_ISTAT: begin
          end
          `RCB_OFS_STATE: begin
          end
          `RCB_OFS_PTR: begin
          end
          default: s_bresp_o <= 2'h2; // unmapped: slverr
        endcase
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
      // set beats write-one-to-clear in the same cycle
      istat_reg <= (istat_reg & ~w1c) |
        {eom_ev, roll_ev};
    end
  end

  // read channel: one cycle answer
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h00000000;
      s_rresp_o <= 2'h0;
    end else if (s_arvalid_i && s_arready_o) begin
      s_rvalid_o <= 1'b1;
      s_rresp_o <= 2'h0;
      case (s_araddr_i)
        `RCB_OFS_CFG2: s_rdata_o <= {16'h0000, cfg2_reg};
        `RCB_OFS_CFG3: s_rdata_o <= {16'h0000, cfg3_reg};
        `RCB_OFS_ISTAT: s_rdata_o <= {30'h00000000, istat_reg};
        `RCB_OFS_IMASK: s_rdata_o <= {30'h00000000, imask_reg};
        `RCB_OFS_STATE: s_rdata_o <= {26'h0000000, wrapped_reg,
          buf_mode_o, state_reg};
        `RCB_OFS_PTR: s_rdata_o <= {{(32-AW){1'b0}}, data_addr_o};
        default: begin
          s_rdata_o <= 32'h00000000;
          s_rresp_o <= 2'h2;
        end
      endcase
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  assign irq_o = |(istat_reg & imask_reg);
endmodule

// File: dv/rcb_top_props.sv
// assertion checker for the rt buffer manager ports
`include "rcb_consts.vh"
module rcb_top_props #(
  parameter AW = 16
) (
  input wire clock_i, rst_n_i, s_awvalid_i, s_awready_o, s_wvalid_i,
  input wire s_wready_o, s_bvalid_o, s_bready_i, s_arvalid_i, s_arready_o,
  input wire s_rvalid_o, s_rready_i, msg_start_i, msg_tx_i, word_step_i,
  input wire msg_end_i, msg_valid_i, busy_o, mem_req_o, mem_we_o, mem_ack_i,
  input wire [1:0] s_bresp_o, buf_mode_o,
  input wire [31:0] s_rdata_o,
  input wire [AW-1:0] desc_addr_i, data_addr_o, mem_addr_o,
  input wire [15:0] mem_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // message phase: 1 setup, 2 transfer, 3 closing
  reg [1:0] ph_reg;
  reg [AW-1:0] desc_reg;
  reg tx_reg;
  // a start while busy is ignored by the block, so it is ignored here too
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ph_reg <= 2'h0;
    end else if (msg_start_i && !busy_o) begin
      ph_reg <= 2'h1;
      desc_reg <= desc_addr_i;
      tx_reg <= msg_tx_i;
    end else if (ph_reg == 2'h1 && mem_ack_i && mem_we_o) begin
      ph_reg <= 2'h2;
    end else if (ph_reg == 2'h2 && msg_end_i) begin
      ph_reg <= 2'h3;
    end else if (ph_reg == 2'h3 && !busy_o) begin
      ph_reg <= 2'h0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // properties
  property p_blat;
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o |-> ##2 s_bvalid_o;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_bhold;
    s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rlat;
    s_arvalid_i && s_arready_o |=> s_rvalid_o;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold;
    s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_start;
    msg_start_i && !busy_o |=> busy_o && mem_req_o && !mem_we_o;
  endproperty
  a_start: assert property (p_start) else $error("no control read");
  property p_mhold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_mhold: assert property (p_mhold) else $error("ram request dropped");
  property p_desc;
    ph_reg == 2'h1 && mem_req_o && mem_we_o |-> mem_addr_o == desc_reg + 2'h2;
  endproperty
  a_desc: assert property (p_desc) else $error("bad descriptor slot");
  property p_step;
    ph_reg == 2'h2 && word_step_i |=>
      data_addr_o == $past(data_addr_o) + 1'b1 ||
      (data_addr_o[6:0] == 7'h00 && data_addr_o < $past(data_addr_o));
  endproperty
  a_step: assert property (p_step) else $error("bad address step");
  property p_wb;
    ph_reg == 2'h2 && msg_end_i && msg_valid_i &&
      buf_mode_o == `RCB_MODE_CIRC |=>
      mem_req_o && mem_we_o && mem_wdata_o == $past(data_addr_o);
  endproperty
  a_wb: assert property (p_wb) else $error("no pointer update");
  property p_single;
    ph_reg == 2'h2 && msg_end_i && buf_mode_o != `RCB_MODE_CIRC |=> !busy_o;
  endproperty
  a_single: assert property (p_single) else $error("single wrote back");
  property p_txdbl;
    ph_reg == 2'h2 && tx_reg |-> buf_mode_o != `RCB_MODE_DOUBLE;
  endproperty
  a_txdbl: assert property (p_txdbl) else $error("transmit doubled");
endmodule
bind rcb_top rcb_top_props #(.AW(AW)) u_props (.*);

// File: dv/rcb_ram_model.sv
// shared ram model answering the manager's memory port
module rcb_ram_model #(
  parameter AW = 16
) (
  input wire clock_i,
  input wire [3:0] lat_i,
  input wire req_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [15:0] wdata_i,
  output reg ack_o = 1'b0,
  output wire [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [15:0] m [0:2047];
  reg [15:0] rd_reg = 16'h0000;
  reg [3:0] cnt_reg = 4'h0;
  // read data is only good beside ack, so garbage is shown otherwise
  assign rdata_o = ack_o ? rd_reg : ~rd_reg;
  // one ack per request after lat_i wait cycles
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    if (req_i && !ack_o) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == lat_i) begin
        ack_o <= 1'b1;
        cnt_reg <= 4'h0;
        if (we_i) m[addr_i[10:0]] <= wdata_i;
        else rd_reg <= m[addr_i[10:0]];
      end
    end
  end
endmodule

// File: dv/rcb_top_test.sv
// self-checking bench for the rt buffer manager
`include "rcb_consts.vh"
module rcb_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg clock_i = 1'b0, rst_n_i = 1'b0;
  reg [7:0] s_awaddr_i = 8'h00, s_araddr_i = 8'h00;
  reg [31:0] s_wdata_i = 32'h0, rv;
  reg [3:0] s_wstrb_i = 4'hF, lat = 4'h0;
  reg s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0, s_arvalid_i = 0;
  reg s_rready_i = 0, msg_start_i = 0, msg_tx_i = 0, msg_bcast_i = 0;
  reg word_step_i = 0, msg_end_i = 0, msg_valid_i = 0;
  reg [4:0] msg_sa_i = 5'h00;
  reg [15:0] desc_addr_i = 16'h0300;
  reg [1:0] rr, br;
  wire s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, busy_o;
  wire mem_req_o, mem_we_o, mem_ack_i, irq_o;
  wire [1:0] s_bresp_o, s_rresp_o, buf_mode_o;
  wire [31:0] s_rdata_o;
  wire [15:0] data_addr_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  integer bad_count = 0, tests_run = 0;
  rcb_top u_dut (.*);
  rcb_ram_model u_ram (.clock_i(clock_i), .lat_i(lat), .req_i(mem_req_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // ==========================================
  // clock, 100 ns period
  initial forever #50 clock_i = ~clock_i;
  // watchdog: whole run is a few hundred cycles
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    conclude;
  end
  // ==========================================
  // shared tasks
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("Error %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg aw, w;
    begin
      s_awaddr_i <= a;
      s_wdata_i <= d;
      s_awvalid_i <= 1'b1;
      s_wvalid_i <= 1'b1;
      s_bready_i <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
        @(posedge clock_i);
        if (aw && s_awready_o) begin
          aw = 1'b0;
          s_awvalid_i <= 1'b0;
        end
        if (w && s_wready_o) begin
          w = 1'b0;
          s_wvalid_i <= 1'b0;
        end
      end
      while (s_bvalid_o !== 1'b1) @(posedge clock_i);
      br = s_bresp_o;
      s_bready_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_araddr_i <= a;
      s_arvalid_i <= 1'b1;
      s_rready_i <= 1'b1;
      do @(posedge clock_i); while (s_arready_o !== 1'b1);
      s_arvalid_i <= 1'b0;
      do @(posedge clock_i); while (s_rvalid_o !== 1'b1);
      rv = s_rdata_o;
      rr = s_rresp_o;
      s_rready_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  // one message: n words from pointer p, wrapping at sz when sz is not 0
  task msg(input [4:0] sa, input [1:0] bt, input v, input [15:0] p,
           input [1:0] md, input integer n, input integer sz);
    integer i;
    reg [15:0] a;
    begin
      msg_sa_i <= sa;
      {msg_bcast_i, msg_tx_i} <= bt;
      msg_start_i <= 1'b1;
      @(posedge clock_i);
      msg_start_i <= 1'b0;
      do @(posedge clock_i); while (!(mem_ack_i && mem_we_o));
      a = p;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clock_i);
        chk("addr", data_addr_o, a);
        word_step_i <= 1'b1;
        @(posedge clock_i);
        word_step_i <= 1'b0;
        a = a + 16'h0001;
        if (sz > 0 && a % sz == 0) a = a - sz;
      end
      chk("mode", buf_mode_o, md);
      msg_end_i <= 1'b1;
      msg_valid_i <= v;
      @(posedge clock_i);
      msg_end_i <= 1'b0;
      do @(posedge clock_i); while (busy_o !== 1'b0);
      chk("desc", u_ram.m[16'h0302], p);
    end
  endtask
  // ==========================================
  // scenarios
  task t_regs;
    begin
      rd(8'h00);
      chk("cfg2", rv, 0);
      rd(8'h40);
      chk("resp", rr, 2);
      chk("rdata", rv, 32'h0);
      wr(8'h40, 32'h0);
      chk("bresp", br, 2'h2);
    end
  endtask
  task t_circ;
    begin
      u_ram.m[16'h01A3] = 16'h0021;
      u_ram.m[16'h0143] = 16'h0400;
      u_ram.m[16'h0183] = 16'h0600;
      msg(3, 2'b00, 1, 16'h0400, `RCB_MODE_SINGLE, 2, 0);
      chk("lut", u_ram.m[16'h0143], 16'h0400);
      wr(8'h00, 32'h0002);
      chk("bresp", br, 2'h0);
      msg(3, 2'b00, 0, 16'h0400, `RCB_MODE_CIRC, 3, 128);
      chk("lut", u_ram.m[16'h0143], 16'h0403);
      lat <= 4'h2;
      wr(8'h00, 32'h0802);
      msg(3, 2'b00, 0, 16'h0403, `RCB_MODE_CIRC, 2, 128);
      chk("lut", u_ram.m[16'h0143], 16'h0403);
      msg(3, 2'b00, 1, 16'h0403, `RCB_MODE_CIRC, 2, 128);
      chk("lut", u_ram.m[16'h0143], 16'h0405);
      wr(8'h00, 32'h0803);
      msg(3, 2'b10, 1, 16'h0600, `RCB_MODE_CIRC, 1, 128);
      chk("blut", u_ram.m[16'h0183], 16'h0601);
      chk("lut", u_ram.m[16'h0143], 16'h0405);
    end
  endtask
  task t_wrap;
    begin
      u_ram.m[16'h01A7] = 16'h0900;
      u_ram.m[16'h0167] = 16'h04FE;
      wr(8'h0C, 32'h0);
      msg(7, 2'b01, 1, 16'h04FE, `RCB_MODE_CIRC, 3, 256);
      chk("lut", u_ram.m[16'h0167], 16'h0401);
      rd(8'h14);
      chk("ptr", rv, 32'h0401);
      rd(8'h10);
      chk("state", rv, 32'h30);
      chk("irq", irq_o, 0);
      rd(8'h08);
      chk("roll", rv & 1, 1);
      wr(8'h0C, 32'h1);
      chk("irq", irq_o, 1);
      wr(8'h08, 32'h1);
      chk("irq", irq_o, 0);
    end
  endtask
  task t_dbl;
    begin
      wr(8'h04, 32'h8000);
      wr(8'h00, 32'h1000);
      msg(3, 2'b00, 1, 16'h0405, `RCB_MODE_DOUBLE, 1, 0);
      msg(7, 2'b01, 1, 16'h0401, `RCB_MODE_SINGLE, 1, 0);
    end
  endtask
  task conclude;
    begin
      $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ==========================================
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_regs;
    t_circ;
    t_wrap;
    t_dbl;
    conclude;
  end
endmodule
